// ---- hw/half_bridge_diag_status.sv ----
// Diagnosis status words and output shut-off logic of a ten-channel half-bridge driver.
//
// Notes on behaviour
// R01 - Word 0: overcurrent, supply fault, open load, active 6..1, side 6..1, thermal warning.
// R02 - Word 1: flags in 15..13, active 10..7 and side 10..7 in bits 10..7 and 4..1, warning 0.
// R03 - Any overload, short or cross-current in a group sets that group's overcurrent flag.
// R04 - An overcurrent latches the flag and switches the affected output stage off.
// R05 - A latched overcurrent flag clears only by the group's clear request or power-on reset.
// R06 - One global supply-fault flag, shown in both words, follows load supply over/undervoltage.
// R07 - While the supply fault is set every half-bridge output is held off.
// R08 - The supply-fault flag does not latch and drops as soon as the supply recovers.
// R09 - Any open-load or underload in a group sets and latches that group's open-load flag.
// R10 - An open load switches the output off only when that group's shut-off enable is high.
// R11 - A latched open-load flag clears only by the group's clear request or power-on reset.
// R12 - Each active-status bit is high while its bridge drives and low while it is high impedance.
// R13 - Each side-status bit is high with the high-side switch on and low-side off, else low.
// R14 - A clear request clears its group's errors on the chip-select rising edge ending the frame.
// R15 - Status bits show the real driver state, not the values written in the control word.
// R16 - Until the first frame ends, word 0 shows only supply fault and thermal warning.
// R17 - Don't-care positions of word 1 read as zero.
module half_bridge_diag_status
  import diag_status_pkg::*;
(
  input wire logic clk, // System clock, 100 MHz
  input wire logic reset_n, // Power-on reset, active low
  input wire logic chip_select_n, // Link chip select pin, active low
  input wire logic [9:0] overcurrent_event, // Per-bridge overload/short/cross-current
  input wire logic [9:0] open_load_event, // Per-bridge open load or underload
  input wire logic load_supply_fault, // Load supply rail out of range
  input wire logic thermal_warning_in, // Junction temperature warning
  input wire logic ctrl_write, // One-cycle pulse: control word received
  input wire logic [15:0] ctrl_word, // Received control word
  output logic [15:0] diag_word_0, // Status of bridges 1 to 6
  output logic [15:0] diag_word_1, // Status of bridges 7 to 10
  output logic [9:0] high_side_switch, // High-side gate drive per bridge
  output logic [9:0] low_side_switch // Low-side gate drive per bridge
);

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  async_in_t async_raw;
  async_in_t async_sync;
  logic cs_n_last_reg;
  logic frame_end;

  assign async_raw = '{overcurrent_event: overcurrent_event,
                       open_load_event: open_load_event,
                       supply_fault: load_supply_fault,
                       thermal_warning: thermal_warning_in,
                       chip_select_n: chip_select_n};

  level_sync #(
    .WIDTH(ASYNC_WIDTH),
    .RESET_VALUE(ASYNC_RESET)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(async_raw),
    .sync_out(async_sync)
  );

  // Chip-select rising edge marks the end of a frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_n_last_reg <= 1'b1;
    end else begin
      cs_n_last_reg <= async_sync.chip_select_n;
    end
  end

  assign frame_end = async_sync.chip_select_n & ~cs_n_last_reg; // see R14

  // ----------------------------------------------------------------------
  // Control word storage
  // ----------------------------------------------------------------------
  logic [9:0] cmd_act_reg;
  logic [9:0] cmd_side_reg;
  logic [1:0] ol_en_reg;
  logic [1:0] clear_pending_reg;
  logic [1:0] group_clear;
  logic ctrl_group;

  assign ctrl_group = ctrl_word[CTRL_GROUP_POS];

  // Commanded bridge states and shut-off enables, per addressed group
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_act_reg <= BRIDGE_RESET;
      cmd_side_reg <= BRIDGE_RESET;
      ol_en_reg <= GROUP_RESET;
    end else if (ctrl_write) begin
      ol_en_reg[ctrl_group] <= ctrl_word[CTRL_OL_EN_POS];
      if (!ctrl_group) begin
        cmd_act_reg[5:0] <= ctrl_word[CTRL_ACT_LSB +: GROUP0_BRIDGES];
        cmd_side_reg[5:0] <= ctrl_word[CTRL_SIDE_LSB +: GROUP0_BRIDGES];
      end else begin
        cmd_act_reg[9:6] <= ctrl_word[CTRL_ACT_LSB +: GROUP1_BRIDGES];
        cmd_side_reg[9:6] <= ctrl_word[CTRL_SIDE_LSB +: GROUP1_BRIDGES];
      end
    end
  end

  // Clear requests wait for the frame end; a new request in that cycle is kept
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clear_pending_reg <= GROUP_RESET;
    end else begin
      for (int g = 0; g < 2; g++) begin
        if (ctrl_write && ctrl_word[CTRL_CLEAR_POS] && (ctrl_group == g[0])) begin
          clear_pending_reg[g] <= 1'b1;
        end else if (frame_end) begin
          clear_pending_reg[g] <= 1'b0; // see R14
        end
      end
    end
  end

  assign group_clear = frame_end ? clear_pending_reg : 2'h0; // see R14

  // ----------------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------------
  logic [1:0] oc_flag_reg;
  logic [1:0] ol_flag_reg;
  logic [1:0] oc_group_evt;
  logic [1:0] ol_group_evt;

  assign oc_group_evt = {|async_sync.overcurrent_event[9:6],
                         |async_sync.overcurrent_event[5:0]}; // see R03
  assign ol_group_evt = {|async_sync.open_load_event[9:6],
                         |async_sync.open_load_event[5:0]}; // see R09

  // Latched flags; a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oc_flag_reg <= GROUP_RESET;
      ol_flag_reg <= GROUP_RESET;
    end else begin
      oc_flag_reg <= (oc_flag_reg & ~group_clear) | oc_group_evt; // see R04 see R05
      ol_flag_reg <= (ol_flag_reg & ~group_clear) | ol_group_evt; // see R09 see R11
    end
  end

  // ----------------------------------------------------------------------
  // Per-bridge shut-off latches and drivers
  // ----------------------------------------------------------------------
  logic [9:0] shutoff_reg;
  logic [9:0] bridge_on;

  for (genvar i = 0; i < NUM_BRIDGES; i++) begin : g_bridge
    localparam int GRP = (i < GROUP0_BRIDGES) ? 0 : 1;

    // Stage stays off until its group is cleared, so a short cannot re-arm itself
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        shutoff_reg[i] <= 1'b0;
      end else if (async_sync.overcurrent_event[i]) begin
        shutoff_reg[i] <= 1'b1; // see R04
      end else if (async_sync.open_load_event[i] && ol_en_reg[GRP]) begin
        shutoff_reg[i] <= 1'b1; // see R10
      end else if (group_clear[GRP]) begin
        shutoff_reg[i] <= 1'b0; // see R05
      end
    end

    // Supply fault overrides everything without latching
    assign bridge_on[i] = cmd_act_reg[i] & ~shutoff_reg[i] & ~async_sync.supply_fault; // see R07
  end

  // Gate drives; the two switches of a bridge are never on together
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      high_side_switch <= BRIDGE_RESET;
      low_side_switch <= BRIDGE_RESET;
    end else begin
      high_side_switch <= bridge_on & cmd_side_reg;
      low_side_switch <= bridge_on & ~cmd_side_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Diagnosis words
  // ----------------------------------------------------------------------
  logic startup_reg;
  logic [9:0] act_status;
  logic [9:0] side_status;

  // Status taken from the real drivers, not from the command bits
  assign act_status = high_side_switch | low_side_switch; // see R12 see R15
  assign side_status = high_side_switch; // see R13 see R15

  // Assemble one word; unused positions stay zero
  function automatic logic [15:0] build_word(input logic oc, input logic supply_fault_flag,
                                             input logic ol, input logic [5:0] act,
                                             input logic [5:0] side, input logic tw);
    logic [15:0] w;
    w = DIAG_WORD_RESET;
    w[DIAG_OC_POS] = oc;
    w[DIAG_PSF_POS] = supply_fault_flag;
    w[DIAG_OL_POS] = ol;
    w[DIAG_ACT_LSB +: 6] = act;
    w[DIAG_SIDE_LSB +: 6] = side;
    w[DIAG_TW_POS] = tw;
    return w;
  endfunction : build_word

  // In word 0, the first frame after reset reports supply and temperature only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      startup_reg <= STARTUP_RESET;
    end else if (frame_end) begin
      startup_reg <= 1'b0; // see R16
    end
  end

  // Words are rebuilt every cycle; supply fault is live in both
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      diag_word_0 <= DIAG_WORD_RESET;
      diag_word_1 <= DIAG_WORD_RESET;
    end else begin
      if (startup_reg) begin
        diag_word_0 <= build_word(1'b0, async_sync.supply_fault, 1'b0, 6'h00, 6'h00,
                                  async_sync.thermal_warning); // see R16
      end else begin
        diag_word_0 <= build_word(oc_flag_reg[0], async_sync.supply_fault, ol_flag_reg[0],
                                  act_status[5:0], side_status[5:0],
                                  async_sync.thermal_warning); // see R01 see R06 see R08
      end
      diag_word_1 <= build_word(oc_flag_reg[1], async_sync.supply_fault, ol_flag_reg[1],
                                {2'h0, act_status[9:6]}, {2'h0, side_status[9:6]},
                                async_sync.thermal_warning); // see R02 see R17
    end
  end

endmodule : half_bridge_diag_status

// ---- hw/diag_status_pkg.sv ----
// Package with the layout and reset values of the half-bridge diagnosis words.
package diag_status_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_BRIDGES = 10;
  localparam int GROUP0_BRIDGES = 6;
  localparam int GROUP1_BRIDGES = 4;
  localparam int WORD_WIDTH = 16;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------------
  // Diagnosis word field positions
  // ----------------------------------------------------------------------
  localparam int DIAG_OC_POS = 15;
  localparam int DIAG_PSF_POS = 14;
  localparam int DIAG_OL_POS = 13;
  localparam int DIAG_ACT_LSB = 7;
  localparam int DIAG_SIDE_LSB = 1;
  localparam int DIAG_TW_POS = 0;

  // ----------------------------------------------------------------------
  // Control word field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_CLEAR_POS = 15;
  localparam int CTRL_GROUP_POS = 14;
  localparam int CTRL_OL_EN_POS = 13;
  localparam int CTRL_ACT_LSB = 7;
  localparam int CTRL_SIDE_LSB = 1;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [15:0] DIAG_WORD_RESET = 16'h0000;
  localparam logic [9:0] BRIDGE_RESET = 10'h000;
  localparam logic [1:0] GROUP_RESET = 2'h0;
  localparam logic STARTUP_RESET = 1'b1;

  // Asynchronous inputs gathered for the synchroniser
  typedef struct packed {
    logic [9:0] overcurrent_event;
    logic [9:0] open_load_event;
    logic supply_fault;
    logic thermal_warning;
    logic chip_select_n;
  } async_in_t;

  localparam int ASYNC_WIDTH = $bits(async_in_t);

  // Synchroniser reset state: every level at its idle value, chip select high
  localparam async_in_t ASYNC_RESET = '{overcurrent_event: 10'h000,
                                        open_load_event: 10'h000,
                                        supply_fault: 1'b0,
                                        thermal_warning: 1'b0,
                                        chip_select_n: 1'b1};

endpackage : diag_status_pkg

// ---- hw/level_sync.sv ----
// Two-stage synchroniser for a vector of levels from outside the clock domain.
module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // Unsynchronised levels
  output logic [WIDTH-1:0] sync_out // Levels safe to read
);

  logic [WIDTH-1:0] meta_reg;

  // ----------------------------------------------------------------------
  // Two flops; only the second stage is read outside
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // Reset to the idle level so that no false edge follows reset
      meta_reg <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : level_sync

// ---- tb/half_bridge_diag_status_assertions.sv ----
// Port-level checks of the half-bridge diagnosis block.
module half_bridge_diag_status_assertions (
  input wire logic clk, // System clock
  input wire logic reset_n, // Reset, active low
  input wire logic chip_select_n, // Frame select pin
  input wire logic [9:0] overcurrent_event, // Overcurrent levels
  input wire logic [9:0] open_load_event, // Open-load levels
  input wire logic load_supply_fault, // Supply out of range
  input wire logic [15:0] diag_word_0, // Word of bridges 1 to 6
  input wire logic [15:0] diag_word_1, // Word of bridges 7 to 10
  input wire logic [9:0] high_side_switch, // High-side drive
  input wire logic [9:0] low_side_switch // Low-side drive
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Level inputs take two edges through the synchroniser first
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  AST_NO_CROSS: assert property ((high_side_switch & low_side_switch) == 10'h000)
    else $error("both switches of a bridge on");
  AST_PSF_OFF: assert property (load_supply_fault [*4] |->
    (high_side_switch | low_side_switch) == 10'h000)
    else $error("drive on during supply fault");
  AST_PSF_SET: assert property (load_supply_fault [*4] |->
    diag_word_0[14] && diag_word_1[14])
    else $error("supply fault not shown");
  AST_PSF_DROP: assert property (!load_supply_fault [*5] |->
    !diag_word_0[14] && !diag_word_1[14])
    else $error("supply fault flag stuck");
  AST_W1_ZERO: assert property (diag_word_1[12:11] == 2'h0 && diag_word_1[6:5] == 2'h0)
    else $error("unused word bits not zero");
  AST_ACT_W1: assert property (diag_word_1[10:7] ==
    $past(high_side_switch[9:6] | low_side_switch[9:6]))
    else $error("active bits differ from drive");
  AST_SIDE_W1: assert property (diag_word_1[4:1] == $past(high_side_switch[9:6]))
    else $error("side bits differ from drive");
  AST_OC_SET: assert property ((overcurrent_event[9:6] != 4'h0) [*5] |->
    diag_word_1[15])
    else $error("overcurrent flag not set");
  AST_OC_OFF: assert property (overcurrent_event[2] [*5] |->
    !high_side_switch[2] && !low_side_switch[2])
    else $error("overcurrent bridge still driven");
  AST_OC_HOLD: assert property ((!chip_select_n) [*6] ##0 diag_word_1[15] |=>
    diag_word_1[15])
    else $error("overcurrent flag dropped in frame");
  AST_OL_SET: assert property ((open_load_event[9:6] != 4'h0) [*5] |-> diag_word_1[13])
    else $error("open-load flag not set");
  AST_OL_HOLD: assert property ((!chip_select_n) [*6] ##0 diag_word_0[13] |=>
    diag_word_0[13])
    else $error("open-load flag dropped in frame");
endmodule : half_bridge_diag_status_assertions

// ---- tb/mcu_link_model.sv ----
// Controller model: frames the chip select around each control word.
module mcu_link_model (
  input wire logic clk, // Bench clock
  output logic chip_select_n, // Frame select, active low
  output logic ctrl_write, // Control word strobe
  output logic [15:0] ctrl_word // Control word
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    chip_select_n = 1'b1;
    ctrl_write = 1'b0;
    ctrl_word = 16'h0000;
  end
  // One frame: sixteen 80 ns link bits, word taken, then frame end
  task automatic send(input logic [15:0] w);
    @(negedge clk);
    chip_select_n = 1'b0;
    repeat (128) @(negedge clk);
    ctrl_word = w;
    ctrl_write = 1'b1;
    @(negedge clk);
    ctrl_write = 1'b0;
    ctrl_word = ~w; // Idle bus shows no stale word
    chip_select_n = 1'b1;
    repeat (16) @(negedge clk); // Gap lets the clear settle first
  endtask : send
endmodule : mcu_link_model

// ---- tb/tb.sv ----
// Self-checking bench of the half-bridge diagnosis words.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset_n, chip_select_n, ctrl_write, load_supply_fault, thermal_warning_in;
  logic [9:0] oc_ev, ol_ev, hs, ls, act, side, off;
  logic [15:0] ctrl_word, w0, w1;
  logic [1:0] oc, ol;
  logic started;
  logic [31:0] seed;
  int error_cnt, tests_run;
  half_bridge_diag_status u_half_bridge_diag_status (.clk(clk), .reset_n(reset_n),
    .chip_select_n(chip_select_n), .overcurrent_event(oc_ev), .open_load_event(ol_ev),
    .load_supply_fault(load_supply_fault), .thermal_warning_in(thermal_warning_in),
    .ctrl_write(ctrl_write), .ctrl_word(ctrl_word), .diag_word_0(w0), .diag_word_1(w1),
    .high_side_switch(hs), .low_side_switch(ls));
  mcu_link_model u_mcu_link_model (.clk(clk), .chip_select_n(chip_select_n),
    .ctrl_write(ctrl_write), .ctrl_word(ctrl_word));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Expected drive and words follow the real drive, not the command
  task automatic check_all(input string name);
    logic [9:0] on;
    on = load_supply_fault ? 10'h000 : act & ~off;
    chk({6'h00, hs}, {6'h00, on & side});
    chk({6'h00, ls}, {6'h00, on & ~side});
    chk(w0, started ? {oc[0], load_supply_fault, ol[0], on[5:0], on[5:0] & side[5:0],
      thermal_warning_in} : {1'b0, load_supply_fault, 13'h0000, thermal_warning_in});
    chk(w1, {oc[1], load_supply_fault, ol[1], 2'b00, on[9:6], 2'b00, on[9:6] & side[9:6],
      thermal_warning_in});
    $display("test %s done, mismatches %0d", name, error_cnt);
  endtask : check_all
  // Unused control bits get random junk; the words must ignore it
  task automatic frame(input logic clr, input logic g, input logic en, input logic [9:0] a,
                       input logic [9:0] s);
    logic [15:0] w;
    logic [9:0] m;
    seed = xs(seed);
    m = g ? 10'h3c0 : 10'h03f;
    if (g) w = {clr, 1'b1, en, seed[1:0], a[9:6], seed[3:2], s[9:6], seed[4]};
    else w = {clr, 1'b0, en, a[5:0], s[5:0], seed[4]};
    u_mcu_link_model.send(w);
    act = (act & ~m) | (a & m);
    side = (side & ~m) | (s & m);
    started = 1'b1;
    if (clr) begin
      oc[g] = 1'b0;
      ol[g] = 1'b0;
      off = off & ~m;
    end
  endtask : frame
  // Fault levels held six cycles, well past the synchroniser
  task automatic pulse(input logic [9:0] o, input logic [9:0] l);
    oc_ev = o;
    ol_ev = l;
    repeat (6) @(negedge clk);
    oc_ev = 10'h000;
    ol_ev = 10'h000;
    repeat (8) @(negedge clk);
  endtask : pulse
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    {reset_n, load_supply_fault, thermal_warning_in, oc_ev, ol_ev} = '0;
    {act, side, off, oc, ol, started} = '0;
    seed = 32'd28805;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    check_all("reset");
    thermal_warning_in = 1'b1;
    // A latched open load must stay hidden in word 0 until the first frame ends
    pulse(10'h000, 10'h001);
    ol[0] = 1'b1;
    check_all("startup");
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      thermal_warning_in = seed[20];
      frame(1'b0, i[0], 1'b0, (i == 2) ? 10'h3ff : seed[9:0], seed[19:10]);
      check_all("random");
    end
    frame(1'b0, 1'b0, 1'b0, 10'h3ff, 10'h155);
    frame(1'b0, 1'b1, 1'b0, 10'h3ff, 10'h155);
    load_supply_fault = 1'b1;
    repeat (6) @(negedge clk);
    check_all("supply fault");
    load_supply_fault = 1'b0;
    repeat (6) @(negedge clk);
    check_all("supply back");
    pulse(10'h204, 10'h000);
    oc = 2'b11;
    off = 10'h204;
    check_all("overcurrent");
    frame(1'b1, 1'b1, 1'b0, act, side);
    check_all("clear other group");
    frame(1'b1, 1'b0, 1'b0, act, side);
    check_all("clear overcurrent");
    pulse(10'h000, 10'h080);
    ol[1] = 1'b1;
    check_all("open load kept on");
    frame(1'b0, 1'b1, 1'b1, act, side);
    pulse(10'h000, 10'h101);
    ol = 2'b11;
    off[8] = 1'b1;
    check_all("open load shutoff");
    frame(1'b1, 1'b1, 1'b1, act, side);
    check_all("clear open load");
    wrap_up();
  end
endmodule : tb

bind half_bridge_diag_status half_bridge_diag_status_assertions u_checker (.clk(clk),
  .reset_n(reset_n), .chip_select_n(chip_select_n), .overcurrent_event(overcurrent_event),
  .open_load_event(open_load_event), .load_supply_fault(load_supply_fault),
  .diag_word_0(diag_word_0), .diag_word_1(diag_word_1),
  .high_side_switch(high_side_switch), .low_side_switch(low_side_switch));
